// ---- hdl/slbc_ctrl.sv ----
// Contract
// - Send BREAK on open timeout or abort
// - Start 1 ms Break timer on BREAK
// - Abort confirmed by BREAK or BREAK_REPLY per method
// - Reply-enabled abort: answer BREAK, keep waiting
// - Break timeout during abort means aborted
// - Start 1 ms Close timer on CLOSE
// - CLOSE confirms; Close timeout falls back to BREAK
// - No connection dwords after sending CLOSE
// - Closed only after CLOSE sent and received
// - After BREAK, discard all but break-related, deletable
// - Break confirmed by BREAK or BREAK_REPLY per method
// - Reply-enabled break: answer BREAK, keep waiting
// - Break timeout means broken; link reset allowed
// - Link reset start breaks any connection
// - Reply method needs capability bit both ways
// - Answer received BREAK per reply method
`timescale 1ns/10ps
`include "slbc_params.svh"
module slbc_ctrl import slbc_pkg::*; #(
	parameter int TIMEOUT_CYCLES = `SLBC_TIMEOUT_CYCLES
) (
	// Clock and reset
	input logic clock,
	input logic srst,
	// Identification exchange
	input logic identify_done,
	input logic local_break_reply_capability_bit,
	input logic remote_break_reply_capability_bit,
	// Connection events and requests
	input logic open_sent,
	input logic open_accepted,
	input logic open_timeout,
	input logic abort_req,
	input logic close_req,
	input logic break_req,
	input logic link_reset_start,
	input logic reset_on_timeout,
	// Received primitives and dwords
	input logic rx_break,
	input logic rx_break_reply,
	input logic rx_close,
	input logic rx_dword_valid,
	input logic rx_deletable,
	// Transmit requests
	output logic tx_break,
	output logic tx_break_reply,
	output logic tx_close,
	output logic conn_dwords_ok,
	// Receive filter
	output logic rx_pass,
	// Results
	output logic reply_en,
	output logic abort_done,
	output logic close_done,
	output logic break_done,
	output logic timed_out,
	output logic link_reset_req
);
	slbc_state_e state, next_state;
	logic replied, next_replied;
	logic close_seen, next_close_seen;
	logic discard, next_discard;
	logic is_abort, next_is_abort;
	logic next_reply_en, next_timed_out;
	logic next_tx_break, next_tx_break_reply, next_tx_close;
	logic next_abort_done, next_close_done, next_break_done, next_link_reset_req;
	logic brk_start, brk_stop, brk_running, brk_expired;
	logic cls_start, cls_stop, cls_running, cls_expired;
	logic peer_break;

	// Break and Close timeout timers
	slbc_timer #(.CYCLES(TIMEOUT_CYCLES)) u_break_timer (
		.clock(clock),
		.srst(srst),
		.start(brk_start),
		.stop(brk_stop),
		.running(brk_running),
		.expired(brk_expired)
	);

	slbc_timer #(.CYCLES(TIMEOUT_CYCLES)) u_close_timer (
		.clock(clock),
		.srst(srst),
		.start(cls_start),
		.stop(cls_stop),
		.running(cls_running),
		.expired(cls_expired)
	);

	assign peer_break = rx_break && (state inside {ST_PENDING, ST_OPEN, ST_CLOSE_WAIT});
	assign brk_stop = (next_state != ST_BREAK_WAIT);
	assign cls_stop = (next_state != ST_CLOSE_WAIT);

	always_comb begin
		next_state = state;
		next_replied = replied;
		next_close_seen = close_seen;
		next_discard = discard;
		next_is_abort = is_abort;
		next_reply_en = reply_en;
		next_timed_out = timed_out;
		next_tx_break = 1'b0;
		next_tx_break_reply = 1'b0;
		next_tx_close = 1'b0;
		next_abort_done = 1'b0;
		next_close_done = 1'b0;
		next_break_done = 1'b0;
		next_link_reset_req = 1'b0;
		brk_start = 1'b0;
		cls_start = 1'b0;
		if (identify_done) begin
			next_reply_en = local_break_reply_capability_bit &&
				remote_break_reply_capability_bit;
		end
		if (link_reset_start) begin
			next_break_done = (state != ST_IDLE);
			next_state = ST_IDLE;
			next_discard = 1'b0;
			next_close_seen = 1'b0;
		end else if (peer_break) begin
			next_tx_break_reply = reply_en;
			next_tx_break = !reply_en;
			next_break_done = 1'b1;
			next_timed_out = 1'b0;
			next_state = ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					next_discard = 1'b0;
					next_close_seen = 1'b0;
					if (open_sent) begin
						next_state = ST_PENDING;
					end
				end
				ST_PENDING: begin
					if (open_accepted) begin
						next_state = ST_OPEN;
						next_close_seen = 1'b0;
					end else if (open_timeout || abort_req) begin
						next_tx_break = 1'b1;
						brk_start = 1'b1;
						next_is_abort = 1'b1;
						next_replied = 1'b0;
						next_discard = 1'b1;
						next_state = ST_BREAK_WAIT;
					end
				end
				ST_OPEN: begin
					if (rx_close) begin
						next_close_seen = 1'b1;
					end
					if (break_req) begin
						next_tx_break = 1'b1;
						brk_start = 1'b1;
						next_is_abort = 1'b0;
						next_replied = 1'b0;
						next_discard = 1'b1;
						next_state = ST_BREAK_WAIT;
					end else if (close_req) begin
						next_tx_close = 1'b1;
						cls_start = 1'b1;
						next_state = ST_CLOSE_WAIT;
					end
				end
				ST_CLOSE_WAIT: begin
					if (close_seen || rx_close) begin
						next_close_done = 1'b1;
						next_timed_out = 1'b0;
						next_state = ST_IDLE;
					end else if (cls_expired) begin
						next_tx_break = 1'b1;
						brk_start = 1'b1;
						next_is_abort = 1'b0;
						next_replied = 1'b0;
						next_discard = 1'b1;
						next_state = ST_BREAK_WAIT;
					end
				end
				ST_BREAK_WAIT: begin
					if (brk_expired) begin
						next_abort_done = is_abort;
						next_break_done = !is_abort;
						next_link_reset_req = !is_abort && reset_on_timeout;
						next_timed_out = 1'b1;
						next_state = ST_IDLE;
					end else if (reply_en) begin
						if (rx_break_reply) begin
							next_abort_done = is_abort;
							next_break_done = !is_abort;
							next_timed_out = 1'b0;
							next_state = ST_IDLE;
						end else if (rx_break && !replied) begin
							next_tx_break_reply = 1'b1;
							next_replied = 1'b1;
						end
					end else if (rx_break) begin
						next_abort_done = is_abort;
						next_break_done = !is_abort;
						next_timed_out = 1'b0;
						next_state = ST_IDLE;
					end
				end
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state <= ST_IDLE;
			replied <= 1'b0;
			close_seen <= 1'b0;
			discard <= 1'b0;
			is_abort <= 1'b0;
			reply_en <= `SLBC_REPLY_EN_RST;
			timed_out <= 1'b0;
			tx_break <= 1'b0;
			tx_break_reply <= 1'b0;
			tx_close <= 1'b0;
			abort_done <= 1'b0;
			close_done <= 1'b0;
			break_done <= 1'b0;
			link_reset_req <= 1'b0;
			conn_dwords_ok <= 1'b0;
			rx_pass <= 1'b0;
		end else begin
			state <= next_state;
			replied <= next_replied;
			close_seen <= next_close_seen;
			discard <= next_discard;
			is_abort <= next_is_abort;
			reply_en <= next_reply_en;
			timed_out <= next_timed_out;
			tx_break <= next_tx_break;
			tx_break_reply <= next_tx_break_reply;
			tx_close <= next_tx_close;
			abort_done <= next_abort_done;
			close_done <= next_close_done;
			break_done <= next_break_done;
			link_reset_req <= next_link_reset_req;
			conn_dwords_ok <= (next_state == ST_OPEN);
			rx_pass <= rx_dword_valid && (!discard || rx_deletable ||
				rx_break || rx_break_reply);
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	sequence s_break_launched;
		##1 (tx_break && brk_running && state == ST_BREAK_WAIT);
	endsequence

	sequence s_quiet_cycle;
		!link_reset_start && !rx_break && !rx_break_reply;
	endsequence

	chk_break_timer_load: assert property (tx_break && state == ST_BREAK_WAIT |-> brk_running)
		else $error("Break timer not running after BREAK");
	chk_close_timer_load: assert property (tx_close |-> cls_running && state == ST_CLOSE_WAIT)
		else $error("Close timer not running after CLOSE");
	chk_timeout_abort: assert property (state == ST_PENDING && open_timeout && !open_accepted
		&& !link_reset_start && !rx_break |-> s_break_launched)
		else $error("Open timeout did not launch BREAK");
	chk_ignore_reply: assert property (state == ST_BREAK_WAIT && !reply_en && !brk_expired
		&& rx_break_reply && !rx_break && !link_reset_start |=> !abort_done && !break_done)
		else $error("BREAK_REPLY not ignored with method disabled");
	chk_answer_reply: assert property (state == ST_BREAK_WAIT && reply_en && !replied
		&& !brk_expired && rx_break && !rx_break_reply && !link_reset_start
		|=> tx_break_reply && state == ST_BREAK_WAIT)
		else $error("BREAK not answered with BREAK_REPLY while waiting");
	chk_timeout_done: assert property (state == ST_BREAK_WAIT && brk_expired && !link_reset_start
		|=> timed_out && (abort_done == is_abort) && (break_done != abort_done) && state == ST_IDLE)
		else $error("Break timeout did not end the wait");
	chk_close_fallback: assert property (((state == ST_CLOSE_WAIT && cls_expired && !close_seen
		&& !rx_close) and s_quiet_cycle) |-> s_break_launched)
		else $error("Close timeout did not fall back to BREAK");
	chk_close_silence: assert property (tx_close |-> !conn_dwords_ok [*2])
		else $error("Connection dwords allowed after CLOSE");
	chk_close_both: assert property (close_done |-> $past(state) == ST_CLOSE_WAIT)
		else $error("Close confirmed without sending CLOSE");
	chk_discard_filter: assert property (discard && rx_dword_valid && !rx_deletable
		&& !rx_break && !rx_break_reply |=> !rx_pass)
		else $error("Dword passed while discarding");
	chk_reset_breaks: assert property (link_reset_start && state != ST_IDLE
		|=> break_done && state == ST_IDLE && !conn_dwords_ok)
		else $error("Link reset did not break connection");
	chk_reply_enable: assert property (identify_done && !remote_break_reply_capability_bit
		|=> !reply_en)
		else $error("Reply method enabled without remote capability");
	chk_peer_answer: assert property (peer_break && !link_reset_start && !identify_done
		|=> (tx_break_reply == reply_en) && (tx_break != reply_en) && break_done)
		else $error("Received BREAK answered with wrong primitive");
endmodule // slbc_ctrl

// ---- hdl/slbc_params.svh ----
`ifndef SLBC_PARAMS_SVH
`define SLBC_PARAMS_SVH

// Link clock period and Break/Close timeout length
`define SLBC_CLOCK_PERIOD_NS 5
`define SLBC_TIMEOUT_NS 1000000
`define SLBC_TIMEOUT_CYCLES ((`SLBC_TIMEOUT_NS) / (`SLBC_CLOCK_PERIOD_NS))

// Reset values
`define SLBC_REPLY_EN_RST 1'b0

`endif

// ---- hdl/slbc_pkg.sv ----
package slbc_pkg;

	// Teardown controller states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE       = 6'h01,
		ST_PENDING    = 6'h02,
		ST_OPEN       = 6'h04,
		ST_CLOSE_WAIT = 6'h08,
		ST_BREAK_WAIT = 6'h10,
		ST_SPARE      = 6'h20
	} slbc_state_e;

endpackage

// ---- hdl/slbc_timer.sv ----
`timescale 1ns/10ps
module slbc_timer import slbc_pkg::*; #(
	parameter int CYCLES = 200000
) (
	// Clock and reset
	input logic clock,
	input logic srst,
	// Control
	input logic start,
	input logic stop,
	// Status
	output logic running,
	output logic expired
);
	localparam int W = $clog2(CYCLES + 1);

	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic next_running;
	logic next_expired;

	// Load on start, count down, one-cycle expiry pulse
	always_comb begin
		next_count = count;
		next_running = running;
		next_expired = 1'b0;
		if (start) begin
			next_count = W'(CYCLES - 1);
			next_running = 1'b1;
		end else if (stop) begin
			next_running = 1'b0;
		end else if (running) begin
			if (count == '0) begin
				next_running = 1'b0;
				next_expired = 1'b1;
			end else begin
				next_count = count - W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			count <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end else begin
			count <= next_count;
			running <= next_running;
			expired <= next_expired;
		end
	end
endmodule // slbc_timer

// ---- sim/slbc_peer_model.sv ----
`timescale 1ns/10ps
module slbc_peer_model (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Bench control: mode 0 answers, 1 silent, 2 answers BREAK, 3 answers BREAK_REPLY
	input wire logic reply_en,
	input wire logic [1:0] mode,
	input wire logic [1:0] dly,
	input wire logic kick,
	// From the block
	input wire logic tx_break,
	input wire logic tx_break_reply,
	input wire logic tx_close,
	// To the block
	output logic rx_break,
	output logic rx_break_reply,
	output logic rx_close
);
	logic [1:0] cnt;
	logic [2:0] kind;

	always_ff @(posedge clock) begin
		{rx_break, rx_break_reply, rx_close} <= 3'h0;
		if (srst) begin
			cnt <= 2'h0;
			kind <= 3'h0;
		end else if (kick) begin
			rx_break <= 1'b1;
		end else if (tx_break && mode != 2'h1) begin
			// Schedule the answer to BREAK after dly, replacing any pending answer
			cnt <= dly;
			kind <= (mode == 2'h3 || (reply_en && mode == 2'h0)) ? 3'h2 : 3'h4;
		end else if (kind != 3'h0) begin
			cnt <= cnt - 2'h1;
			if (cnt == 2'h0) begin
				{rx_break, rx_break_reply, rx_close} <= kind;
				kind <= 3'h0;
			end
		end else if (mode != 2'h1) begin
			cnt <= dly;
			if (tx_close)
				kind <= 3'h1;
			else if (tx_break_reply)
				kind <= 3'h2;
		end
	end
endmodule // slbc_peer_model

// ---- sim/tb_sas_link_break_close_control.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("CHECK FAILED %0t value mismatch", $time); end end
module tb_sas_link_break_close_control;
	localparam int TO = 20;
	localparam int OS = 0, OA = 1, OT = 2, AB = 3, CR = 4, BR = 5, LK = 6, ID = 7;
	logic clock, srst, lcap, rcap, rot;
	logic dv, dd, kick;
	logic [7:0] req;
	logic [1:0] mode, dly;
	logic rxb, rxr, rxc, txb, txr, txc, cok, rx_pass, reply_en, ad, cd, bd, tmo, lrq;
	logic [6:0] outv, exp_v;
	logic [6:0] q[$];
	int failures = 0, n_tests = 0, cyc = 0, seed = 44048;

	always #2.5 clock = ~clock;
	assign outv = {txb, txr, txc, ad, cd, bd, lrq};

	slbc_ctrl #(.TIMEOUT_CYCLES(TO)) dut (.clock(clock), .srst(srst),
		.identify_done(req[ID]), .local_break_reply_capability_bit(lcap),
		.remote_break_reply_capability_bit(rcap), .open_sent(req[OS]),
		.open_accepted(req[OA]), .open_timeout(req[OT]), .abort_req(req[AB]),
		.close_req(req[CR]), .break_req(req[BR]), .link_reset_start(req[LK]),
		.reset_on_timeout(rot), .rx_break(rxb), .rx_break_reply(rxr), .rx_close(rxc),
		.rx_dword_valid(dv), .rx_deletable(dd), .tx_break(txb), .tx_break_reply(txr),
		.tx_close(txc), .conn_dwords_ok(cok), .rx_pass(rx_pass), .reply_en(reply_en),
		.abort_done(ad), .close_done(cd), .break_done(bd), .timed_out(tmo),
		.link_reset_req(lrq));

	slbc_peer_model peer (.clock(clock), .srst(srst), .reply_en(reply_en), .mode(mode),
		.dly(dly), .kick(kick), .tx_break(txb), .tx_break_reply(txr), .tx_close(txc),
		.rx_break(rxb), .rx_break_reply(rxr), .rx_close(rxc));

	// Result watcher: oldest note against each output event
	always @(posedge clock) begin
		if (!srst && outv !== 7'h0) begin
			exp_v = (q.size() > 0) ? q.pop_front() : 7'h0;
			`CHK(outv, exp_v)
		end
	end

	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			conclude();
		end
	end

	task automatic conclude();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic step(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic pulse(int i);
		req[i] = 1'b1;
		dly = 2'($random(seed));
		step(1);
		req[i] = 1'b0;
	endtask

	task automatic finish_test(string s);
		for (int i = 0; i < 200 && q.size() > 0; i++)
			step(1);
		step(3);
		`CHK(q.size(), 0)
		$display("test %s done", s);
	endtask

	task automatic ident(logic l, logic r);
		lcap = l;
		rcap = r;
		pulse(ID);
		step(1);
		`CHK(reply_en, l & r)
	endtask

	task automatic open_conn();
		pulse(OS);
		pulse(OA);
		step(1);
		`CHK(cok, 1'b1)
	endtask

	initial begin
		clock = 1'b0;
		srst = 1'b1;
		{lcap, rcap, rot, dv, dd, kick} = 6'h0;
		req = 8'h0;
		mode = 2'h0;
		dly = 2'h0;
		step(20);
		srst = 1'b0;
		for (int i = 0; i < 4; i++)
			ident(i[1], i[0]);
		ident(1'b0, 1'b0);
		q.push_back(7'h40);
		q.push_back(7'h08);
		pulse(OS);
		pulse(OT);
		finish_test("abort_no_reply");
		`CHK(tmo, 1'b0)
		mode = 2'h3;
		q.push_back(7'h40);
		q.push_back(7'h08);
		pulse(OS);
		pulse(OT);
		finish_test("abort_reply_ignored");
		`CHK(tmo, 1'b1)
		ident(1'b1, 1'b1);
		mode = 2'h2;
		q.push_back(7'h40);
		q.push_back(7'h20);
		q.push_back(7'h08);
		pulse(OS);
		pulse(AB);
		finish_test("abort_reply");
		mode = 2'h1;
		q.push_back(7'h40);
		q.push_back(7'h08);
		pulse(OS);
		pulse(OT);
		finish_test("abort_timeout");
		`CHK(tmo, 1'b1)
		mode = 2'h0;
		q.push_back(7'h10);
		q.push_back(7'h04);
		open_conn();
		pulse(CR);
		`CHK(cok, 1'b0)
		finish_test("close");
		mode = 2'h1;
		rot = 1'b1;
		q.push_back(7'h10);
		q.push_back(7'h40);
		q.push_back(7'h03);
		open_conn();
		pulse(CR);
		step(TO + 5);
		for (int i = 0; i < 4; i++) begin
			dv = 1'b1;
			dd = i[0] & 1'($random(seed));
			step(1);
			dv = 1'b0;
			`CHK(rx_pass, dd)
		end
		finish_test("close_timeout_break");
		`CHK(tmo, 1'b1)
		mode = 2'h0;
		q.push_back(7'h40);
		q.push_back(7'h20);
		q.push_back(7'h02);
		open_conn();
		kick = 1'b1;
		pulse(BR);
		kick = 1'b0;
		finish_test("break_crossing");
		q.push_back(7'h22);
		open_conn();
		kick = 1'b1;
		step(1);
		kick = 1'b0;
		finish_test("peer_break");
		q.push_back(7'h02);
		open_conn();
		pulse(LK);
		finish_test("link_reset");
		conclude();
	end
endmodule // tb_sas_link_break_close_control
